// ==== src/ast_consts.svh ====
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH

// register map and field layout
`define AST_ADDR_W           16
`define AST_DATA_W           8
`define AST_REG_DMA_RECOVERY 16'hf0df
`define AST_CNT_W            5
`define AST_CNT_MSB          4
`define AST_RSV_MSB          7
`define AST_RSV_LSB          5
`define AST_RCV_RESET        5'h00
`define AST_RSV_VALUE        3'h0
`define AST_RDATA_IDLE       8'h00

// phase lengths, counted in controller clock periods
`define AST_LEN_W            6
`define AST_LEN_ZERO         6'h00
`define AST_LEN_ONE          6'h01
`define AST_PIO_AST_EXTRA    6'h01
`define AST_PIO_REC_EXTRA    6'h02
`define AST_MW_AST_EXTRA     6'h01
`define AST_MW_REC_EXTRA     6'h02
`define AST_UD_AST_EXTRA     6'h02
`define AST_UD_REC_EXTRA     6'h01

// controller clock period in picoseconds (one recovery unit)
`define AST_CTRL_PERIOD_PS   16670

`endif

// ==== src/ast_pkg.sv ====
`include "ast_consts.svh"

package ast_pkg;

   // transfer kind selected per cycle
   typedef enum logic [1:0] {
      AST_MODE_PIO   = 2'h0,
      AST_MODE_MWDMA = 2'h1,
      AST_MODE_UDMA  = 2'h2
   } ast_mode_type;

   // strobe sequencer states
   typedef enum logic [1:0] {
      AST_ST_IDLE    = 2'h0,
      AST_ST_ASSERT  = 2'h1,
      AST_ST_RECOVER = 2'h2
   } ast_state_type;

   // firmware register bus request
   typedef struct packed {
      logic [`AST_ADDR_W-1:0] addr;
      logic [`AST_DATA_W-1:0] wdata;
      logic                   wr;
      logic                   rd;
   } ast_bus_req_type;

   // assertion and recovery settings held by neighbouring registers
   typedef struct packed {
      logic [`AST_CNT_W-1:0] pio_assert;
      logic [`AST_CNT_W-1:0] pio_recover;
      logic [`AST_CNT_W-1:0] dma_assert;
   } ast_timing_type;

endpackage

// ==== src/ast_phase_counter.sv ====
`timescale 1ns/10ps
`include "ast_consts.svh"

module ast_phase_counter
   import ast_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  load,
   input  wire logic [`AST_LEN_W-1:0] load_len,
   output logic      [`AST_LEN_W-1:0] cnt_ff,
   output logic                       last
);

   // cycles left in the running phase, one per controller clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= `AST_LEN_ZERO;
      end else if (load) begin
         cnt_ff <= load_len;
      end else if (cnt_ff != `AST_LEN_ZERO) begin
         cnt_ff <= cnt_ff - `AST_LEN_ONE;
      end
   end

   // final cycle of the phase
   assign last = (cnt_ff == `AST_LEN_ONE);

endmodule // ast_phase_counter

// ==== src/ast_strobe_timing.sv ====
// Operation
// - power-up or watchdog reset clears recovery register
// - USB reset leaves recovery register untouched
// - recovery counted in whole controller clock periods
// - multiword DMA recovery is setting plus two
// - ultra DMA recovery is setting plus one
// - multiword DMA write holds data two cycles
// - five-bit count, bits seven to five read zero
// - PIO and multiword assertion is setting plus one
// - PIO recovery is setting plus two
// - whole sequencer runs on the controller clock
// - DMA assertion adds one multiword, two ultra
`timescale 1ns/10ps
`include "ast_consts.svh"

module ast_strobe_timing
   import ast_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   wdt_rst,
   input  wire logic                   usb_rst,
   input  wire ast_bus_req_type        bus,
   output logic      [`AST_DATA_W-1:0] rdata_ff,
   input  wire ast_timing_type         timing,
   input  wire logic                   xfer_start,
   input  wire ast_mode_type           xfer_mode,
   input  wire logic                   xfer_write,
   output logic                        strobe_ff,
   output logic                        hold_ff,
   output logic                        busy_ff,
   output logic                        done_ff
);

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   logic [`AST_CNT_W-1:0] dma_recovery_count_ff; // programmed recovery setting
   logic                  reg_hit;               // address decode
   logic                  wr_hit;                // write to the recovery register

   assign reg_hit = (bus.addr == `AST_REG_DMA_RECOVERY);
   assign wr_hit  = bus.wr && reg_hit;

   // usb_rst deliberately has no path here so firmware timing survives a bus reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dma_recovery_count_ff <= `AST_RCV_RESET;
      end else if (wdt_rst) begin
         dma_recovery_count_ff <= `AST_RCV_RESET;
      end else if (wr_hit) begin
         dma_recovery_count_ff <= bus.wdata[`AST_CNT_MSB:0];
      end
   end

   // read data; reserved bits and unmapped addresses read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= `AST_RDATA_IDLE;
      end else if (bus.rd && reg_hit) begin
         rdata_ff <= {`AST_RSV_VALUE, dma_recovery_count_ff};
      end else begin
         rdata_ff <= `AST_RDATA_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // phase length selection

   logic [`AST_LEN_W-1:0] nxt_ast_len;  // assertion length for a new cycle
   logic [`AST_LEN_W-1:0] nxt_rec_len;  // recovery length for a new cycle
   logic [`AST_LEN_W-1:0] ast_len_ff;   // latched assertion length
   logic [`AST_LEN_W-1:0] rec_len_ff;   // latched recovery length
   logic                  mw_write_ff;  // cycle is a multiword DMA write

   // settings are widened by one bit before the fixed overhead is added
   always_comb begin
      case (xfer_mode)
         AST_MODE_PIO: begin
            nxt_ast_len = {1'b0, timing.pio_assert} + `AST_PIO_AST_EXTRA;
            nxt_rec_len = {1'b0, timing.pio_recover} + `AST_PIO_REC_EXTRA;
         end
         AST_MODE_MWDMA: begin
            nxt_ast_len = {1'b0, timing.dma_assert} + `AST_MW_AST_EXTRA;
            nxt_rec_len = {1'b0, dma_recovery_count_ff} + `AST_MW_REC_EXTRA;
         end
         AST_MODE_UDMA: begin
            nxt_ast_len = {1'b0, timing.dma_assert} + `AST_UD_AST_EXTRA;
            nxt_rec_len = {1'b0, dma_recovery_count_ff} + `AST_UD_REC_EXTRA;
         end
         default: begin
            // unknown mode falls back to the PIO settings and the PIO overhead
            nxt_ast_len = {1'b0, timing.pio_assert} + `AST_PIO_AST_EXTRA;
            nxt_rec_len = {1'b0, timing.pio_recover} + `AST_PIO_REC_EXTRA;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer

   ast_state_type         state_ff;     // current phase
   ast_state_type         nxt_state;    // next phase
   logic                  cnt_load;     // reload the phase counter
   logic [`AST_LEN_W-1:0] cnt_len;      // value for the reload
   logic [`AST_LEN_W-1:0] cnt_ff;       // cycles left in phase
   logic                  cnt_last;     // last cycle of phase

   ast_phase_counter u_phase_counter (
      .clk      (clk),
      .rst_n    (rst_n),
      .load     (cnt_load),
      .load_len (cnt_len),
      .cnt_ff   (cnt_ff),
      .last     (cnt_last)
   );

   // assertion runs first, then recovery, then back to idle
   always_comb begin
      nxt_state = state_ff;
      cnt_load  = 1'b0;
      cnt_len   = nxt_ast_len;
      case (state_ff)
         AST_ST_IDLE: begin
            if (xfer_start) begin
               nxt_state = AST_ST_ASSERT;
               cnt_load  = 1'b1;
               cnt_len   = nxt_ast_len;
            end
         end
         AST_ST_ASSERT: begin
            if (cnt_last) begin
               nxt_state = AST_ST_RECOVER;
               cnt_load  = 1'b1;
               cnt_len   = rec_len_ff;
            end
         end
         AST_ST_RECOVER: begin
            if (cnt_last) begin
               nxt_state = AST_ST_IDLE;
            end
         end
         default: begin
            nxt_state = AST_ST_IDLE;
         end
      endcase
   end

   // state register, clocked by the single controller clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= AST_ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // cycle parameters are frozen at start so register writes cannot stretch a live cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ast_len_ff  <= `AST_LEN_ZERO;
         rec_len_ff  <= `AST_LEN_ZERO;
         mw_write_ff <= 1'b0;
      end else if (state_ff == AST_ST_IDLE && xfer_start) begin
         ast_len_ff  <= nxt_ast_len;
         rec_len_ff  <= nxt_rec_len;
         mw_write_ff <= xfer_write && (xfer_mode == AST_MODE_MWDMA);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   // strobe high exactly while the assertion phase runs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_ff <= 1'b0;
      end else begin
         strobe_ff <= (nxt_state == AST_ST_ASSERT);
      end
   end

   // busy for the whole cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != AST_ST_IDLE);
      end
   end

   // one-cycle pulse after the last recovery cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_ff <= 1'b0;
      end else begin
         done_ff <= (state_ff == AST_ST_RECOVER) && cnt_last;
      end
   end

   // write data hold covers the first two recovery cycles, inside the two extra ones
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_ff <= 1'b0;
      end else if (state_ff == AST_ST_ASSERT && cnt_last) begin
         hold_ff <= mw_write_ff;
      end else if (state_ff == AST_ST_RECOVER) begin
         hold_ff <= hold_ff && (cnt_ff == rec_len_ff);
      end else begin
         hold_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   logic [`AST_LEN_W-1:0] phase_cyc_ff; // cycles spent in the current phase

   // helper count of phase cycles for the length checks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_cyc_ff <= `AST_LEN_ZERO;
      end else if (nxt_state != state_ff) begin
         phase_cyc_ff <= `AST_LEN_ZERO;
      end else begin
         phase_cyc_ff <= phase_cyc_ff + `AST_LEN_ONE;
      end
   end

   wdt_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      wdt_rst |=> (dma_recovery_count_ff == `AST_RCV_RESET))
      else $error("watchdog reset did not clear recovery count");

   usb_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (usb_rst && !wdt_rst && !wr_hit) |=> $stable(dma_recovery_count_ff))
      else $error("recovery count changed on usb reset");

   reg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_hit && !wdt_rst) |=> (dma_recovery_count_ff == $past(bus.wdata[`AST_CNT_MSB:0])))
      else $error("recovery count write lost");

   rsv_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && reg_hit) |=> (rdata_ff[`AST_RSV_MSB:`AST_RSV_LSB] == `AST_RSV_VALUE)
         && (rdata_ff[`AST_CNT_MSB:0] == $past(dma_recovery_count_ff)))
      else $error("recovery register read wrong");

   assert_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == AST_ST_ASSERT && nxt_state != AST_ST_ASSERT)
         |-> (phase_cyc_ff + `AST_LEN_ONE == ast_len_ff))
      else $error("assertion phase length wrong");

   recov_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == AST_ST_RECOVER && nxt_state != AST_ST_RECOVER)
         |-> (phase_cyc_ff + `AST_LEN_ONE == rec_len_ff))
      else $error("recovery phase length wrong");

   hold_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(hold_ff) |-> hold_ff[*2] ##1 !hold_ff)
      else $error("write data hold not two cycles");

   strobe_order_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(strobe_ff) |-> busy_ff && !strobe_ff && (state_ff == AST_ST_RECOVER))
      else $error("recovery did not follow assertion");

   mode_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == AST_ST_IDLE && xfer_start && xfer_mode == AST_MODE_UDMA)
         |=> (rec_len_ff == {1'b0, $past(dma_recovery_count_ff)} + `AST_UD_REC_EXTRA))
      else $error("ultra recovery overhead wrong");

   // a start taken while idle must raise strobe and busy on the next cycle
   start_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff == AST_ST_IDLE && xfer_start) |=> (strobe_ff && busy_ff))
      else $error("cycle start not answered");

   // done only in the cycle right after busy drops
   done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      done_ff |-> (!busy_ff && $past(busy_ff)))
      else $error("done pulse out of place");

   // a live cycle keeps its latched recovery length even if firmware writes
   freeze_len_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_ff != AST_ST_IDLE) |=> $stable(rec_len_ff))
      else $error("recovery length changed inside a cycle");

endmodule // ast_strobe_timing

// ==== sim/ast_drive_model.sv ====
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////
// drive side: a passive meter of strobe phases, one count per clock edge
module ast_drive_model (
   input  wire logic       clk,
   input  wire logic       start,   // cycle request seen at the port
   input  wire logic       strobe,  // strobe from the bridge
   input  wire logic       busy,    // bridge cycle in flight
   input  wire logic       hold,    // write data hold from the bridge
   output logic      [7:0] a_len,   // measured assertion clocks
   output logic      [7:0] r_len,   // measured recovery clocks
   output logic      [7:0] h_len    // measured hold clocks
);
   // a start taken while idle opens a new measurement; the drive never stalls here
   always_ff @(posedge clk) begin
      if (start && !busy) begin
         a_len <= 8'h00;
         r_len <= 8'h00;
         h_len <= 8'h00;
      end else begin
         if (strobe) a_len <= a_len + 8'h01;
         if (busy && !strobe) r_len <= r_len + 8'h01;
         if (hold) h_len <= h_len + 8'h01;
      end
   end
endmodule // ast_drive_model

// ==== sim/test_ast_strobe_timing.sv ====
`timescale 1ns/10ps
`include "ast_consts.svh"

module test_ast_strobe_timing
   import ast_pkg::*;
   ;
   logic            clk, rst_n, wdt_rst, usb_rst;  // clock and resets
   logic            xfer_start, xfer_write;        // cycle request
   ast_mode_type    xfer_mode;                     // cycle kind
   ast_bus_req_type bus;                           // register bus
   ast_timing_type  timing;                        // neighbour settings
   logic      [7:0] rdata_ff, a_len, r_len, h_len; // observed values
   logic            strobe_ff, hold_ff, busy_ff, done_ff;
   int              miscompares, cmp_count;

   //////////////////////////////////////////////////////////////////////
   ast_strobe_timing dut_u (.clk(clk), .rst_n(rst_n), .wdt_rst(wdt_rst), .usb_rst(usb_rst),
      .bus(bus), .rdata_ff(rdata_ff), .timing(timing), .xfer_start(xfer_start),
      .xfer_mode(xfer_mode), .xfer_write(xfer_write), .strobe_ff(strobe_ff),
      .hold_ff(hold_ff), .busy_ff(busy_ff), .done_ff(done_ff));
   ast_drive_model drv_u (.clk(clk), .start(xfer_start), .strobe(strobe_ff),
      .busy(busy_ff), .hold(hold_ff), .a_len(a_len), .r_len(r_len), .h_len(h_len));

   //////////////////////////////////////////////////////////////////////
   // 20 ns clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   // read data lands on the same edge that takes the strobe
   task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata_ff;
   endtask

   task automatic t_reg;
      logic [7:0] d;
      reg_rd(`AST_REG_DMA_RECOVERY, d);
      chk(d, 8'h00);
      reg_wr(`AST_REG_DMA_RECOVERY, 8'hff);
      reg_rd(`AST_REG_DMA_RECOVERY, d);
      chk(d, 8'h1f);
      reg_wr(16'hf0de, 8'h05); // unmapped here, must be ignored
      reg_rd(16'hf0de, d);
      chk(d, 8'h00);
      reg_rd(`AST_REG_DMA_RECOVERY, d);
      chk(d, 8'h1f);
      $display("test reg done");
   endtask

   task automatic t_rst;
      logic [7:0] d;
      reg_wr(`AST_REG_DMA_RECOVERY, 8'h0a);
      @(posedge clk) usb_rst <= 1'b1;
      repeat (3) @(posedge clk);
      usb_rst <= 1'b0;
      reg_rd(`AST_REG_DMA_RECOVERY, d);
      chk(d, 8'h0a);
      @(posedge clk) wdt_rst <= 1'b1;
      @(posedge clk) wdt_rst <= 1'b0;
      reg_rd(`AST_REG_DMA_RECOVERY, d);
      chk(d, 8'h00);
      // watchdog and write in one cycle: the clear must win
      @(posedge clk);
      bus <= '{addr: `AST_REG_DMA_RECOVERY, wdata: 8'h07, wr: 1'b1, rd: 1'b0};
      wdt_rst <= 1'b1;
      @(posedge clk);
      bus <= '0;
      wdt_rst <= 1'b0;
      reg_rd(`AST_REG_DMA_RECOVERY, d);
      chk(d, 8'h00);
      reg_wr(`AST_REG_DMA_RECOVERY, 8'h0b);
      @(posedge clk) rst_n <= 1'b0; // power-up reset in mid-run
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      reg_rd(`AST_REG_DMA_RECOVERY, d);
      chk(d, 8'h00);
      $display("test resets done");
   endtask

   // one full strobe cycle, judged by the drive model and by its length
   task automatic xfer(input ast_mode_type m, input logic w, input logic [4:0] pa, pr, da, rc,
                       input logic [7:0] ea, er, eh);
      int n;
      reg_wr(`AST_REG_DMA_RECOVERY, {3'h0, rc});
      @(posedge clk);
      timing <= '{pio_assert: pa, pio_recover: pr, dma_assert: da};
      xfer_mode <= m;
      xfer_write <= w;
      xfer_start <= 1'b1;
      @(posedge clk);
      xfer_start <= 1'b0;
      #1;
      for (n = 0; n < 100 && done_ff !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      chk({7'h00, done_ff}, 8'h01);
      chk(a_len, ea);
      chk(r_len, er);
      chk(h_len, eh);
      chk(8'(n), ea + er);
   endtask

   // settings as firmware would pick them after asking the drive its modes
   task automatic t_xfer;
      xfer(AST_MODE_PIO, 1'b1, 5'd17, 5'd16, 5'd0, 5'd0, 8'd18, 8'd18, 8'd0);
      xfer(AST_MODE_MWDMA, 1'b1, 5'd0, 5'd0, 5'd12, 5'd14, 8'd13, 8'd16, 8'd2);
      xfer(AST_MODE_MWDMA, 1'b0, 5'd0, 5'd0, 5'd31, 5'd31, 8'd32, 8'd33, 8'd0);
      xfer(AST_MODE_MWDMA, 1'b1, 5'd9, 5'd9, 5'd0, 5'd0, 8'd1, 8'd2, 8'd2);
      xfer(AST_MODE_UDMA, 1'b1, 5'd0, 5'd0, 5'd5, 5'd9, 8'd7, 8'd10, 8'd0);
      xfer(AST_MODE_UDMA, 1'b0, 5'd3, 5'd3, 5'd0, 5'd0, 8'd2, 8'd1, 8'd0);
      xfer(ast_mode_type'(2'h3), 1'b0, 5'd0, 5'd0, 5'd7, 5'd7, 8'd1, 8'd2, 8'd0);
      $display("test transfers done");
   endtask

   // a second start while busy is ignored; the first cycle keeps its lengths
   task automatic t_refuse;
      @(posedge clk);
      timing <= '{pio_assert: 5'd4, pio_recover: 5'd1, dma_assert: 5'd0};
      xfer_mode <= AST_MODE_PIO;
      xfer_write <= 1'b0;
      xfer_start <= 1'b1;
      @(posedge clk);
      xfer_start <= 1'b0;
      @(posedge clk);
      timing <= '{pio_assert: 5'd20, pio_recover: 5'd20, dma_assert: 5'd0};
      xfer_start <= 1'b1;
      @(posedge clk);
      xfer_start <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk({7'h00, done_ff}, 8'h01);
      chk(a_len, 8'd5);
      chk(r_len, 8'd3);
      $display("test refused start done");
   endtask

   task automatic summarize;
      $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////
   // the tests need a few thousand ns; a hang is cut at a generous margin
   initial begin
      #100000;
      miscompares++;
      summarize();
   end

   initial begin
      rst_n = 1'b0;
      wdt_rst = 1'b0;
      usb_rst = 1'b0;
      bus = '0;
      timing = '0;
      xfer_start = 1'b0;
      xfer_write = 1'b0;
      xfer_mode = AST_MODE_PIO;
      miscompares = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reg();
      t_rst();
      t_xfer();
      t_refuse();
      summarize();
   end
endmodule // test_ast_strobe_timing
